// file: rtl/clock_distribution_dividers.sv
// Clock distribution: source select, prescaler, four channel dividers,
// twelve output pairs and the zero-delay feedback selector.
// Assumes osc_in and ext_clk_in are slow against mclk and asynchronous.
//
// Functional notes
// - Mode field 01b selects internal zero delay.
// - Internal mode feeds divider zero back.
// - Mode field 11b takes feedback from clock pin.
// - Board loops an output to the clock pin.
// - Each channel drives three output pairs.
// - Divide 1 to 32; one only by bypass.
// - Prescaler divides source by 1 to 6.
// - High N+1, low M+1 input cycles.
// - Correction needs M=N+1, not prescaler one.
// - Coarse delay up to 15 input cycles.
// - Programmable start level high or low.
// - Source field: 00,01 clock pin; 10 oscillator.
// - Oscillator may go straight to drivers.
// - Total division is prescaler times divider.
// - Prescaler bypass differs from ratio one.
// - All dividers stay synchronised together.
// - M and N fields are four bits.
// - Correction on after reset, per-channel disable.
// - Prescaler has a static setting.
`timescale 1ns/1ps
`default_nettype none
module clock_distribution_dividers (
	input  wire logic        mclk,
	input  wire logic        reset,
	input  wire logic [9:0]  addr,
	input  wire logic [7:0]  wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [7:0]  rdata,
	input  wire logic        osc_in,
	input  wire logic        ext_clk_in,
	output logic      [11:0] out_p,
	output logic      [11:0] out_n,
	output logic             fb_clk,
	output logic      [1:0]  fb_channel
);
	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [7:0] zd_cfg_reg;
	logic [7:0] src_reg;
	logic [7:0] pre_reg;
	logic [7:0] div_reg [clkdist_pkg::NUM_CH];
	logic [7:0] ctl_reg [clkdist_pkg::NUM_CH];
	logic [7:0] dcc_reg [clkdist_pkg::NUM_CH];
	logic       sync_reg;
	logic       sync_next;
	logic [7:0] rdata_next;
	logic [7:0] ch_rd [clkdist_pkg::NUM_CH];
	logic [3:0] hit_div;
	logic [3:0] hit_ctl;
	logic [3:0] hit_dcc;
	logic       hit_zd;
	logic       hit_src;
	logic       hit_pre;
	logic       hit_sync;
	logic       hit_stat;

	assign hit_zd   = addr == clkdist_pkg::ZD_CFG_ADDR;
	assign hit_src  = addr == clkdist_pkg::SRC_ADDR;
	assign hit_pre  = addr == clkdist_pkg::PRE_ADDR;
	assign hit_sync = addr == clkdist_pkg::SYNC_ADDR;
	assign hit_stat = addr == clkdist_pkg::STAT_ADDR;

	// ------------------------------------------------------------
	// Pin synchronisers and source selection
	// ------------------------------------------------------------
	logic osc_s1;
	logic osc_s2;
	logic ext_s1;
	logic ext_s2;
	logic src_prev;
	logic src_lvl;
	logic src_tick;
	clkdist_pkg::src_mode_t src_mode;
	clkdist_pkg::zd_mode_t  zd_mode;
	logic bad_src;
	logic pre_dir;
	logic [2:0] pre_code;

	always_ff @(posedge mclk) begin
		osc_s1   <= osc_in;
		osc_s2   <= osc_s1;
		ext_s1   <= ext_clk_in;
		ext_s2   <= ext_s1;
		src_prev <= src_lvl;
	end

	assign src_mode = clkdist_pkg::src_mode_t'(src_reg[1:0]);
	assign zd_mode  = clkdist_pkg::zd_mode_t'(
		zd_cfg_reg[clkdist_pkg::ZD_MODE_LSB +: 2]);
	assign bad_src  = src_mode == clkdist_pkg::SRC_BAD;
	assign src_lvl  = (src_mode == clkdist_pkg::SRC_OSC_PRE)
		? osc_s2 : ext_s2;
	assign src_tick = src_lvl && !src_prev;
	assign pre_dir  = src_mode == clkdist_pkg::SRC_EXT_DIR;
	// The illegal source code parks the prescaler so nothing toggles.
	assign pre_code = bad_src ? clkdist_pkg::PRE_STATIC : pre_reg[2:0];

	// ------------------------------------------------------------
	// Prescaler and channel dividers
	// ------------------------------------------------------------
	logic p_tick;
	logic p_mid;
	logic p_lvl;
	logic pre_one;
	logic [3:0] ch_lvl;
	logic [3:0] dcc_act;
	logic [3:0] ch_out;

	// Dividers count the prescaled ticks, so ratios multiply.
	prescaler u_pre (
		.mclk      (mclk),
		.reset     (reset),
		.sync      (sync_reg),
		.src_tick  (src_tick),
		.src_level (src_lvl),
		.code      (pre_code),
		.direct    (pre_dir),
		.tick      (p_tick),
		.mid       (p_mid),
		.level     (p_lvl)
	);

	assign pre_one = !pre_dir && (pre_code == clkdist_pkg::PRE_ONE);

	genvar i;
	generate
		for (i = 0; i < clkdist_pkg::NUM_CH; i++) begin : g_ch
			localparam logic [9:0] BASE =
				clkdist_pkg::CH_BASE + 10'(i) * clkdist_pkg::CH_STRIDE;
			logic odd_ok;
			logic byp;
			assign hit_div[i] = addr == BASE;
			assign hit_ctl[i] = addr == BASE + clkdist_pkg::CH_CTL_OFS;
			assign hit_dcc[i] = addr == BASE + clkdist_pkg::CH_DCC_OFS;
			assign ch_rd[i] = hit_div[i] ? div_reg[i]
				: hit_ctl[i] ? ctl_reg[i]
				: hit_dcc[i] ? dcc_reg[i] : 8'h00;
			assign byp = ctl_reg[i][clkdist_pkg::BYPASS_BIT];
			assign odd_ok = div_reg[i][7:4] == div_reg[i][3:0] + 4'h1;
			assign dcc_act[i] = !dcc_reg[i][clkdist_pkg::DCC_DIS_BIT]
				&& odd_ok && !pre_one && !pre_dir;
			// One shared divider per channel; sync restarts all together.
			channel_divider u_div (
				.mclk       (mclk),
				.reset      (reset),
				.sync       (sync_reg),
				.tick       (p_tick),
				.mid        (p_mid),
				.pre_level  (p_lvl),
				.m          (div_reg[i][7:4]),
				.n          (div_reg[i][3:0]),
				.phase      (ctl_reg[i][3:0]),
				.start_high (ctl_reg[i][clkdist_pkg::START_BIT]),
				.bypass     (byp),
				.dcc        (dcc_act[i]),
				.level      (ch_lvl[i])
			);
			assign ch_out[i] =
				(src_mode == clkdist_pkg::SRC_OSC_PRE
				 && ctl_reg[i][clkdist_pkg::OSCDIR_BIT]) ? osc_s2
				: (bad_src || (pre_one && byp)) ? 1'b0
				: ch_lvl[i];
		end
	endgenerate

	// ------------------------------------------------------------
	// Zero-delay feedback
	// ------------------------------------------------------------
	logic fb_next;

	assign fb_next = (zd_mode == clkdist_pkg::ZD_INT) ? ch_out[0]
		: (zd_mode == clkdist_pkg::ZD_EXT) ? ext_s2
		: 1'b0;

	// ------------------------------------------------------------
	// Register writes and reads
	// ------------------------------------------------------------
	logic cfg_wr;

	// Any change of divider or source settings except the DCC disable resynchronises all.
	assign cfg_wr = wr && (hit_src || hit_pre || (|hit_div)
		|| (|hit_ctl));
	assign sync_next = cfg_wr
		|| (wr && hit_sync && wdata[clkdist_pkg::SYNC_BIT]);

	always_comb begin
		rdata_next = hit_zd ? zd_cfg_reg
			: hit_src ? src_reg
			: hit_pre ? pre_reg
			: hit_stat ? {3'h0, fb_clk, ch_out} : 8'h00;
		for (int k = 0; k < clkdist_pkg::NUM_CH; k++) begin
			rdata_next = rdata_next | ch_rd[k];
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			zd_cfg_reg <= clkdist_pkg::ZD_CFG_RST;
			src_reg    <= clkdist_pkg::SRC_RST;
			pre_reg    <= clkdist_pkg::PRE_RST;
		end else if (wr) begin
			if (hit_zd) zd_cfg_reg <= wdata;
			if (hit_src) src_reg <= wdata;
			if (hit_pre) pre_reg <= wdata;
		end
	end

	always_ff @(posedge mclk) begin
		for (int k = 0; k < clkdist_pkg::NUM_CH; k++) begin
			if (reset) begin
				div_reg[k] <= clkdist_pkg::CH_DIV_RST;
				ctl_reg[k] <= clkdist_pkg::CH_CTL_RST;
				dcc_reg[k] <= clkdist_pkg::CH_DCC_RST;
			end else if (wr) begin
				if (hit_div[k]) div_reg[k] <= wdata;
				if (hit_ctl[k]) ctl_reg[k] <= wdata;
				if (hit_dcc[k]) dcc_reg[k] <= wdata;
			end
		end
	end

	// ------------------------------------------------------------
	// Output flops
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (reset) begin
			rdata      <= 8'h00;
			sync_reg   <= 1'b1;
			fb_clk     <= 1'b0;
			fb_channel <= 2'h0;
			out_p      <= 12'h000;
			out_n      <= 12'hFFF;
		end else begin
			rdata      <= rd ? rdata_next : 8'h00;
			sync_reg   <= sync_next;
			fb_clk     <= fb_next;
			// Calibration needs the feedback divider number.
			fb_channel <= zd_cfg_reg[clkdist_pkg::ZD_SEL_LSB +: 2];
			for (int k = 0; k < 12; k++) begin
				out_p[k] <= ch_out[k / clkdist_pkg::OUTS];
				out_n[k] <= !ch_out[k / clkdist_pkg::OUTS];
			end
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	zd_int_a: assert property (zd_mode == clkdist_pkg::ZD_INT
		|=> fb_clk == $past(ch_out[0]))
		else $error("internal feedback not from divider zero");
	zd_ext_a: assert property (zd_mode == clkdist_pkg::ZD_EXT
		|=> fb_clk == $past(ext_s2))
		else $error("external feedback not from clock pin");
	zd_off_a: assert property (zd_mode[0] == 1'b0 |=> !fb_clk)
		else $error("feedback active with zero delay off");
	illegal_hold_a: assert property (pre_one && !bad_src
		&& ctl_reg[0][clkdist_pkg::BYPASS_BIT]
		&& !ctl_reg[0][clkdist_pkg::OSCDIR_BIT] |=> !out_p[0])
		else $error("illegal ratio pair not static");
	bad_src_a: assert property (bad_src && !osc_s2 |=> out_p == 12'h000)
		else $error("outputs toggle on illegal source");
	dcc_gate_a: assert property (pre_one |-> dcc_act == 4'h0)
		else $error("correction active with ratio one");
	pair_out_a: assert property (out_n == ~out_p)
		else $error("output pair not complementary");
	resync_a: assert property (cfg_wr |=> sync_reg)
		else $error("configuration write did not resync");
	read_data_a: assert property (rd && hit_zd
		|=> rdata == $past(zd_cfg_reg) ##1 rdata == 8'h00)
		else $error("read data wrong or held too long");
endmodule : clock_distribution_dividers
`default_nettype wire

// file: rtl/clkdist_pkg.sv
// Constants for the clock distribution block.
// Assumes an 8-bit register port with 10-bit addresses.
package clkdist_pkg;
	localparam int NUM_CH = 4;
	localparam int OUTS = 3;
	localparam logic [9:0] ZD_CFG_ADDR = 10'h01E;
	localparam logic [9:0] PRE_ADDR    = 10'h1E0;
	localparam logic [9:0] SRC_ADDR    = 10'h1E1;
	localparam logic [9:0] STAT_ADDR   = 10'h1E3;
	localparam logic [9:0] SYNC_ADDR   = 10'h230;
	localparam logic [9:0] CH_BASE     = 10'h190;
	localparam logic [9:0] CH_STRIDE   = 10'h003;
	localparam logic [9:0] CH_CTL_OFS  = 10'h001;
	localparam logic [9:0] CH_DCC_OFS  = 10'h002;
	localparam int ZD_MODE_LSB = 1;
	localparam int ZD_SEL_LSB  = 3;
	localparam int BYPASS_BIT  = 7;
	localparam int OSCDIR_BIT  = 5;
	localparam int START_BIT   = 4;
	localparam int DCC_DIS_BIT = 0;
	localparam int SYNC_BIT    = 0;
	localparam logic [7:0] ZD_CFG_RST = 8'h00;
	localparam logic [7:0] SRC_RST    = 8'h02;
	localparam logic [7:0] PRE_RST    = 8'h01;
	localparam logic [7:0] CH_DIV_RST = 8'h00;
	localparam logic [7:0] CH_CTL_RST = 8'h10;
	localparam logic [7:0] CH_DCC_RST = 8'h00;
	localparam logic [2:0] PRE_ONE    = 3'h0;
	localparam logic [2:0] PRE_STATIC = 3'h6;
	typedef enum logic [1:0] {
		ZD_OFF = 2'b00,
		ZD_INT = 2'b01,
		ZD_RSV = 2'b10,
		ZD_EXT = 2'b11
	} zd_mode_t;
	typedef enum logic [1:0] {
		SRC_EXT_PRE = 2'b00,
		SRC_EXT_DIR = 2'b01,
		SRC_OSC_PRE = 2'b10,
		SRC_BAD     = 2'b11
	} src_mode_t;
	typedef enum logic [1:0] {
		ST_WAIT = 2'b00,
		ST_HIGH = 2'b01,
		ST_HALF = 2'b10,
		ST_LOW  = 2'b11
	} div_st_t;
endpackage : clkdist_pkg

// file: rtl/prescaler.sv
// Prescaler between the selected source and the channel dividers.
// Assumes one-cycle source ticks and a common sync pulse.
`timescale 1ns/1ps
`default_nettype none
module prescaler (
	input  wire logic       mclk,
	input  wire logic       reset,
	input  wire logic       sync,
	input  wire logic       src_tick,
	input  wire logic       src_level,
	input  wire logic [2:0] code,
	input  wire logic       direct,
	output logic            tick,
	output logic            mid,
	output logic            level
);
	logic [2:0] cnt_reg;
	logic [2:0] cnt_next;
	logic [2:0] last;
	logic [2:0] half;
	logic       stat;
	logic       pass;
	logic       wrap;
	logic       fall_prev;
	logic       src_fall;
	logic       odd_ratio;

	// Odd ratios need the extra half cycle on a falling source edge,
	// otherwise correction stretches the high phase by a whole cycle.
	assign src_fall  = fall_prev && !src_level;
	assign odd_ratio = (code[0] == 1'b0);
	assign stat  = !direct && (code >= clkdist_pkg::PRE_STATIC);
	assign pass  = direct || (code == clkdist_pkg::PRE_ONE);
	assign last  = code;
	assign half  = (code + 3'h1) >> 1;
	assign wrap  = src_tick && (cnt_reg == last);
	assign cnt_next = wrap ? 3'h0 : cnt_reg + 3'h1;
	// Ratios 1 to 6: one tick per ratio source ticks.
	assign tick  = stat ? 1'b0 : (pass ? src_tick : wrap);
	assign mid   = !stat && !pass && (odd_ratio
		? (src_fall && (cnt_reg == half))
		: (src_tick && (cnt_reg == half - 3'h1)));
	assign level = stat ? 1'b0 : (pass ? src_level : (cnt_reg < half));

	always_ff @(posedge mclk) begin
		fall_prev <= src_level;
	end

	always_ff @(posedge mclk) begin
		if (reset || sync || stat || pass) begin
			cnt_reg <= 3'h0;
		end else if (src_tick) begin
			cnt_reg <= cnt_next;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	static_hold_a: assert property (stat |-> !tick && !level)
		else $error("static prescaler toggles");
	ratio_tick_a: assert property (!pass && !stat && tick |-> cnt_reg == code)
		else $error("prescaler tick at wrong count");
endmodule : prescaler
`default_nettype wire

// file: rtl/channel_divider.sv
// One channel divider: high N+1, low M+1, delay, start level, DCC.
// Assumes ticks and mid ticks come from the prescaler.
`timescale 1ns/1ps
`default_nettype none
module channel_divider (
	input  wire logic       mclk,
	input  wire logic       reset,
	input  wire logic       sync,
	input  wire logic       tick,
	input  wire logic       mid,
	input  wire logic       pre_level,
	input  wire logic [3:0] m,
	input  wire logic [3:0] n,
	input  wire logic [3:0] phase,
	input  wire logic       start_high,
	input  wire logic       bypass,
	input  wire logic       dcc,
	output logic            level
);
	clkdist_pkg::div_st_t st_reg;
	clkdist_pkg::div_st_t st_next;
	logic [3:0] cnt_reg;
	logic [3:0] cnt_next;
	logic       lvl_reg;
	logic       lvl_next;

	assign level = bypass ? pre_level : lvl_reg;

	always_comb begin
		st_next  = st_reg;
		cnt_next = cnt_reg;
		lvl_next = lvl_reg;
		unique case (st_reg)
			clkdist_pkg::ST_WAIT: if (tick) begin
				cnt_next = cnt_reg + 4'h1;
				if (cnt_reg == phase) begin
					cnt_next = 4'h0;
					st_next  = start_high ? clkdist_pkg::ST_HIGH
					                      : clkdist_pkg::ST_LOW;
				end
			end
			clkdist_pkg::ST_HIGH: if (tick) begin
				cnt_next = cnt_reg + 4'h1;
				if (cnt_reg == n) begin
					cnt_next = 4'h0;
					st_next  = dcc ? clkdist_pkg::ST_HALF
					               : clkdist_pkg::ST_LOW;
					lvl_next = dcc;
				end
			end
			// Falls half an input cycle late so odd ratios land at 50%.
			clkdist_pkg::ST_HALF: if (mid) begin
				st_next  = clkdist_pkg::ST_LOW;
				lvl_next = 1'b0;
			end
			clkdist_pkg::ST_LOW: if (tick) begin
				cnt_next = cnt_reg + 4'h1;
				if (cnt_reg == m) begin
					cnt_next = 4'h0;
					st_next  = clkdist_pkg::ST_HIGH;
					lvl_next = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			st_reg  <= clkdist_pkg::ST_WAIT;
			cnt_reg <= 4'h0;
			lvl_reg <= 1'b1;
		end else if (sync) begin
			st_reg  <= clkdist_pkg::ST_WAIT;
			cnt_reg <= 4'h0;
			lvl_reg <= start_high;
		end else begin
			st_reg  <= st_next;
			cnt_reg <= cnt_next;
			lvl_reg <= lvl_next;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	start_level_a: assert property (sync |=> lvl_reg == $past(start_high))
		else $error("divider did not restart at start level");
	high_end_a: assert property (st_reg == clkdist_pkg::ST_HIGH && tick
		&& cnt_reg == n && !dcc && !sync |=> !lvl_reg)
		else $error("high phase length wrong");
	phase_wait_a: assert property (st_reg == clkdist_pkg::ST_WAIT && tick
		&& cnt_reg != phase && !sync |=> st_reg == clkdist_pkg::ST_WAIT)
		else $error("coarse delay ended early");
endmodule : channel_divider
`default_nettype wire

// file: tb/board_model.sv
// Board around the clock distribution block: oscillator, clock pin source
// and the optional loop from one output back to the clock pin.
// Assumes the bench chooses when the loop is closed and which output.
`timescale 1ns/1ps
`default_nettype none
module board_model (
	input  wire logic loop_en,
	input  wire logic loop_pin,
	output logic      osc_in,
	output logic      ext_clk_in
);
	logic ext_free;

	// The odd start offset keeps both sources out of phase with mclk.
	initial begin
		osc_in = 1'b0;
		ext_free = 1'b0;
		#37;
		fork
			forever #400 osc_in = ~osc_in;
			forever #300 ext_free = ~ext_free;
		join
	end

	assign ext_clk_in = loop_en ? loop_pin : ext_free;
endmodule : board_model
`default_nettype wire

// file: tb/test_clock_distribution_dividers.sv
// Self-checking bench for the clock distribution block.
// Assumes oscillator period of 8 and clock pin period of 6 mclk cycles.
`timescale 1ns/1ps
`default_nettype none
module test_clock_distribution_dividers;
	logic        mclk, reset, wr, rd, loop_en;
	logic        osc_in, ext_clk_in, fb_clk;
	logic [9:0]  addr;
	logic [7:0]  wdata, rdata;
	logic [11:0] out_p, out_n;
	logic [1:0]  fb_channel;
	int          n_errors, n_compared;

	clock_distribution_dividers clock_distribution_dividers_i (
		.mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .osc_in(osc_in),
		.ext_clk_in(ext_clk_in), .out_p(out_p), .out_n(out_n),
		.fb_clk(fb_clk), .fb_channel(fb_channel));
	board_model board_model_i (.loop_en(loop_en), .loop_pin(out_p[3]),
		.osc_in(osc_in), .ext_clk_in(ext_clk_in));

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [15:0] got, exp, input string m);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask : chk

	function automatic logic [9:0] ca(input int c, input logic [9:0] o);
		return clkdist_pkg::CH_BASE + 10'(c) * clkdist_pkg::CH_STRIDE + o;
	endfunction : ca

	task automatic wreg(input logic [9:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask : wreg

	task automatic rreg(input logic [9:0] a, input logic [7:0] e);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		@(negedge mclk);
		chk({8'h00, rdata}, {8'h00, e}, "register read");
	endtask : rreg

	// Lengths are in mclk cycles from one rising output edge.
	task automatic meas(input int i, input int hi, input int lo);
		int h, l, k;
		repeat (20) @(negedge mclk);
		for (k = 0; k < 999 && out_p[i] === 1'b1; k++) @(negedge mclk);
		for (k = 0; k < 999 && out_p[i] === 1'b0; k++) @(negedge mclk);
		for (h = 0; h < 999 && out_p[i] === 1'b1; h++) @(negedge mclk);
		for (l = 0; l < 999 && out_p[i] === 1'b0; l++) @(negedge mclk);
		chk(16'(h), 16'(hi), "high length");
		chk(16'(l), 16'(lo), "low length");
	endtask : meas

	task automatic still(input int i, input logic z);
		logic v;
		int   k, n;
		repeat (20) @(negedge mclk);
		v = out_p[i];
		n = 0;
		for (k = 0; k < 200; k++) begin
			@(negedge mclk);
			if (out_p[i] !== v) n++;
		end
		chk(16'(n), 16'h0000, "output toggles");
		if (z) chk({15'h0000, v}, 16'h0000, "static level");
	endtask : still

	task automatic fbcount(input int i);
		int   a, b, k;
		logic pa, pb;
		a = 0;
		b = 0;
		pa = fb_clk;
		pb = out_p[i];
		for (k = 0; k < 480; k++) begin
			@(negedge mclk);
			if (fb_clk === 1'b1 && pa === 1'b0) a++;
			if (out_p[i] === 1'b1 && pb === 1'b0) b++;
			pa = fb_clk;
			pb = out_p[i];
		end
		chk({15'h0000, a > 3 && a - b <= 1 && b - a <= 1}, 16'h0001,
			"feedback edges");
	endtask : fbcount

	always @(negedge mclk) begin
		if (!reset) begin
			chk({4'h0, out_n}, {4'h0, ~out_p}, "complement");
			chk({4'h0, out_p}, {4'h0, {3{out_p[9]}}, {3{out_p[6]}},
				{3{out_p[3]}}, {3{out_p[0]}}}, "group");
		end
	end

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		rreg(clkdist_pkg::ZD_CFG_ADDR, 8'h00);
		rreg(clkdist_pkg::SRC_ADDR, 8'h02);
		rreg(clkdist_pkg::PRE_ADDR, 8'h01);
		rreg(ca(0, 10'h000), 8'h00);
		rreg(ca(1, clkdist_pkg::CH_CTL_OFS), 8'h10);
		rreg(ca(3, clkdist_pkg::CH_DCC_OFS), 8'h00);
		rreg(10'h3FF, 8'h00);
		chk({14'h0000, fb_channel}, 16'h0000, "feedback channel");
	endtask : t_reset

	task automatic t_div();
		wreg(clkdist_pkg::SRC_ADDR, 8'h01);
		wreg(ca(0, 10'h000), 8'h21);
		meas(0, 12, 18);
		wreg(ca(0, 10'h000), 8'hF0);
		meas(0, 6, 96);
		wreg(ca(0, 10'h000), 8'h0F);
		meas(0, 96, 6);
	endtask : t_div

	task automatic t_pre();
		wreg(clkdist_pkg::SRC_ADDR, 8'h02);
		wreg(ca(0, clkdist_pkg::CH_CTL_OFS), 8'h90);
		for (int r = 2; r <= 6; r++) begin
			wreg(clkdist_pkg::PRE_ADDR, 8'(r - 1));
			meas(0, (r / 2) * 8, (r - r / 2) * 8);
		end
		wreg(clkdist_pkg::PRE_ADDR, 8'h06);
		still(0, 1'b0);
		wreg(clkdist_pkg::PRE_ADDR, 8'h00);
		still(0, 1'b1);
		wreg(clkdist_pkg::SRC_ADDR, 8'h01);
		meas(0, 3, 3);
		wreg(clkdist_pkg::SRC_ADDR, 8'h00);
		still(0, 1'b1);
	endtask : t_pre

	task automatic t_prod();
		wreg(clkdist_pkg::SRC_ADDR, 8'h02);
		wreg(clkdist_pkg::PRE_ADDR, 8'h02);
		wreg(ca(0, clkdist_pkg::CH_CTL_OFS), 8'h10);
		wreg(ca(0, clkdist_pkg::CH_DCC_OFS), 8'h01);
		wreg(ca(0, 10'h000), 8'h00);
		meas(0, 24, 24);
		wreg(ca(0, 10'h000), 8'h10);
		meas(0, 24, 48);
		wreg(ca(0, clkdist_pkg::CH_DCC_OFS), 8'h00);
		meas(0, 36, 36);
		wreg(clkdist_pkg::PRE_ADDR, 8'h00);
		meas(0, 8, 16);
	endtask : t_prod

	task automatic t_phase();
		int f0, f1, k;
		wreg(clkdist_pkg::PRE_ADDR, 8'h01);
		wreg(ca(0, 10'h000), 8'h11);
		wreg(ca(1, 10'h000), 8'h11);
		wreg(ca(1, clkdist_pkg::CH_CTL_OFS), 8'h1F);
		wreg(ca(2, clkdist_pkg::CH_CTL_OFS), 8'h00);
		wreg(clkdist_pkg::SYNC_ADDR, 8'h01);
		repeat (5) @(negedge mclk);
		chk({14'h0000, out_p[6], out_p[0]}, 16'h0001, "start");
		f0 = 0;
		f1 = 0;
		for (k = 1; k < 999 && (f0 == 0 || f1 == 0); k++) begin
			@(negedge mclk);
			if (f0 == 0 && out_p[0] === 1'b0) f0 = k;
			if (f1 == 0 && out_p[3] === 1'b0) f1 = k;
		end
		chk(16'(f1 - f0), 16'h00F0, "phase delay");
	endtask : t_phase

	task automatic t_zd();
		wreg(ca(1, 10'h000), 8'h22);
		wreg(clkdist_pkg::ZD_CFG_ADDR, 8'h02);
		fbcount(0);
		loop_en <= 1'b1;
		wreg(clkdist_pkg::ZD_CFG_ADDR, 8'h0E);
		rreg(clkdist_pkg::ZD_CFG_ADDR, 8'h0E);
		chk({14'h0000, fb_channel}, 16'h0001, "feedback channel");
		fbcount(3);
		loop_en <= 1'b0;
	endtask : t_zd

	task automatic t_mode();
		wreg(clkdist_pkg::SRC_ADDR, 8'h03);
		still(0, 1'b1);
		still(9, 1'b1);
		wreg(clkdist_pkg::SRC_ADDR, 8'h02);
		wreg(ca(0, clkdist_pkg::CH_CTL_OFS), 8'h30);
		meas(0, 4, 4);
	endtask : t_mode

	// ------------------------------------------------------------
	// Run control
	// ------------------------------------------------------------
	task automatic complete_run();
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : complete_run

	initial begin
		reset = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 10'h000;
		wdata = 8'h00;
		loop_en = 1'b0;
		n_errors = 0;
		n_compared = 0;
		repeat (3) @(posedge mclk);
		reset <= 1'b0;
		t_reset();
		t_div();
		t_pre();
		t_prod();
		t_phase();
		t_zd();
		t_mode();
		complete_run();
	end

	// The scenarios need about 4000 cycles; fifteen times that is a hang.
	initial begin
		repeat (60000) @(posedge mclk);
		n_errors++;
		$display("wrong value at %0t: run did not finish", $time);
		complete_run();
	end
endmodule : test_clock_distribution_dividers
`default_nettype wire
